// ---- design/scr_pkg.sv ----
// constants for the serial controller command and data register front end
// What this block does
// - command registers are write-only; command bits clear themselves once the action starts
// - software reset acts like hardware reset, lasts four clocks, default mode after
// - interrupt acknowledge forces interrupt output inactive for two clocks
// - status clear clears receive, modem and timer status together
// - power-down command enters power-down mode
// - flush transmit machine resets its logic only, then enables transmission
// - flush transmit fifo empties the transmit fifo
// - transmit enable starts sending; disable waits for current character to finish
// - receive enable allows reception; receive disable stops it
// - flush receive machine resets its logic, enables reception, unlocks fifo writes
// - flush receive fifo empties the receive fifo
// - lock blocks receive fifo writes; reception and status reporting continue
// - unlock re-enables receive fifo writes
// - timer command writes ignored for a timer used as baud generator
// - timer gate bits enable counting when 1, and keep their written value
// - timer start triggers timer; terminal count sets its expired status bit
// - modem control bits drive their pins inverted, only for general outputs
// - loopback bit enables loopback of the type chosen in a mode register
// - transmit data write pushes byte plus transmit flags into the transmit fifo
// - transmit flags give address marker, software parity and ninth data bits
// - receive data shows oldest character; reading loads next entry into data and flags
package scr_pkg;
    localparam logic [3:0] ADDR_DEVICE_COMMAND   = 4'h0;
    localparam logic [3:0] ADDR_TRANSMIT_COMMAND = 4'h1;
    localparam logic [3:0] ADDR_RECEIVE_COMMAND  = 4'h2;
    localparam logic [3:0] ADDR_TIMER_COMMAND    = 4'h3;
    localparam logic [3:0] ADDR_MODEM_CONTROL    = 4'h4;
    localparam logic [3:0] ADDR_TX_DATA          = 4'h5;
    localparam logic [3:0] ADDR_TX_FLAGS         = 4'h6;
    localparam logic [3:0] ADDR_RX_DATA          = 4'h7;
    localparam logic [3:0] ADDR_RX_FLAGS         = 4'h8;
    localparam logic [3:0] ADDR_STATE            = 4'h9;
    // device command bits
    localparam int BIT_SOFT_RESET   = 0;
    localparam int BIT_INT_ACK      = 1;
    localparam int BIT_STATUS_CLEAR = 2;
    localparam int BIT_POWER_DOWN   = 3;
    // transmit command bits
    localparam int BIT_FLUSH_TXM = 0;
    localparam int BIT_FLUSH_TXF = 1;
    localparam int BIT_TX_EN     = 2;
    localparam int BIT_TX_DIS    = 3;
    // receive command bits
    localparam int BIT_RX_EN     = 0;
    localparam int BIT_RX_DIS    = 1;
    localparam int BIT_FLUSH_RXM = 2;
    localparam int BIT_FLUSH_RXF = 3;
    localparam int BIT_LOCK_RXF  = 4;
    localparam int BIT_OPEN_RXF  = 5;
    // timer command bits
    localparam int BIT_START_A = 0;
    localparam int BIT_START_B = 1;
    localparam int BIT_GATE_A  = 2;
    localparam int BIT_GATE_B  = 3;
    // modem control bits
    localparam int BIT_DTR  = 0;
    localparam int BIT_RTS  = 1;
    localparam int BIT_GP_OUTPUT_ONE = 2;
    localparam int BIT_GP_OUTPUT_TWO = 3;
    localparam int BIT_LOOP = 4;
    localparam int BIT_GP_OUTPUT_ZERO = 5;
    // transmit flags bits
    localparam int BIT_NINTH   = 0;
    localparam int BIT_PARITY  = 1;
    localparam int BIT_ADDRMRK = 2;
    localparam logic [7:0] MODEM_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [2:0] TX_FLAG_MASK = 3'h7;
    // timing in clocks
    localparam int SOFT_RESET_CLOCKS = 4;
    localparam int INT_ACK_CLOCKS    = 2;
endpackage

// ---- design/scr_regs.sv ----
// command and data register front end of the serial controller
`timescale 1ns/1ps
module scr_regs #(
    parameter int RX_WIDTH = 8
) (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic [3:0]          addr,
    input  wire logic [7:0]          wrData,
    input  wire logic                wrStrobe,
    input  wire logic                rdStrobe,
    output logic      [7:0]          rdData,
    // surrounding device
    input  wire logic                intRequest,
    output logic                     intOut,
    output logic                     deviceReset,
    output logic                     statusClear,
    output logic                     powerDown,
    output logic                     flushTxMachine,
    output logic                     flushTxFifo,
    output logic                     txEnable,
    input  wire logic                txBusy,
    output logic                     flushRxMachine,
    output logic                     flushRxFifo,
    output logic                     rxEnable,
    output logic                     rxFifoLocked,
    input  wire logic                timerABaud,
    input  wire logic                timerBBaud,
    output logic                     timerAGate,
    output logic                     timerBGate,
    output logic                     timerAStart,
    output logic                     timerBStart,
    input  wire logic                timerATerminal,
    input  wire logic                timerBTerminal,
    output logic                     timerAExpired,
    output logic                     timerBExpired,
    input  wire logic [5:0]          pinIsGpOut,
    output logic                     dtrPin,
    output logic                     rtsPin,
    output logic                     gpOutputOne,
    output logic                     gpOutputTwo,
    output logic                     gpOutputZero,
    output logic                     loopbackActive,
    output logic [RX_WIDTH+2:0]      txPushData,
    output logic                     txPush,
    input  wire logic                txFifoFull,
    input  wire logic                rxFifoValid,
    input  wire logic [7:0]          rxFifoData,
    input  wire logic [7:0]          rxFifoFlags,
    output logic                     rxFifoPop
);
    logic [2:0] softCount;
    logic [1:0] ackCount;
    logic [7:0] modemControl;
    logic [7:0] txFlags;
    logic [7:0] rxDataHead;
    logic [7:0] rxFlags;
    logic       rxHeadValid;
    logic       txStopPending;
    logic       wrDev;
    logic       wrTx;
    logic       wrRx;
    logic       wrTm;
    logic       rdRxData;
    logic       softActive;

    assign wrDev = wrStrobe && addr == scr_pkg::ADDR_DEVICE_COMMAND;
    assign wrTx = wrStrobe && addr == scr_pkg::ADDR_TRANSMIT_COMMAND;
    assign wrRx = wrStrobe && addr == scr_pkg::ADDR_RECEIVE_COMMAND;
    assign wrTm = wrStrobe && addr == scr_pkg::ADDR_TIMER_COMMAND;
    assign rdRxData = rdStrobe && addr == scr_pkg::ADDR_RX_DATA;
    assign softActive = softCount != 3'h0;

    // software reset stretcher; counter itself only sees the hardware reset
    always_ff @(posedge clk) begin
        if (reset) begin
            softCount <= 3'h0;
        end else if (wrDev && wrData[scr_pkg::BIT_SOFT_RESET]) begin
            softCount <= 3'(scr_pkg::SOFT_RESET_CLOCKS);
        end else if (softActive) begin
            softCount <= softCount - 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            deviceReset <= 1'b1;
        end else begin
            deviceReset <= (wrDev && wrData[scr_pkg::BIT_SOFT_RESET]) || softCount > 3'h1;
        end
    end

    // one-cycle command pulses: nothing latches, so a second write is never needed
    always_ff @(posedge clk) begin
        if (reset || softActive) begin
            statusClear    <= 1'b0;
            flushTxMachine <= 1'b0;
            flushTxFifo    <= 1'b0;
            flushRxMachine <= 1'b0;
            flushRxFifo    <= 1'b0;
            timerAStart    <= 1'b0;
            timerBStart    <= 1'b0;
        end else begin
            statusClear    <= wrDev && wrData[scr_pkg::BIT_STATUS_CLEAR];
            flushTxMachine <= wrTx && wrData[scr_pkg::BIT_FLUSH_TXM];
            flushTxFifo    <= wrTx && wrData[scr_pkg::BIT_FLUSH_TXF];
            flushRxMachine <= wrRx && wrData[scr_pkg::BIT_FLUSH_RXM];
            flushRxFifo    <= wrRx && wrData[scr_pkg::BIT_FLUSH_RXF];
            timerAStart    <= wrTm && !timerABaud && wrData[scr_pkg::BIT_START_A];
            timerBStart    <= wrTm && !timerBBaud && wrData[scr_pkg::BIT_START_B];
        end
    end

    // interrupt acknowledge blanking
    always_ff @(posedge clk) begin
        if (reset || softActive) begin
            ackCount <= 2'h0;
        end else if (wrDev && wrData[scr_pkg::BIT_INT_ACK]) begin
            // the write cycle itself blanks the first clock, the counter the rest
            ackCount <= 2'(scr_pkg::INT_ACK_CLOCKS - 1);
        end else if (ackCount != 2'h0) begin
            ackCount <= ackCount - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || softActive) begin
            intOut <= 1'b0;
        end else begin
            // pending requests reappear once the blanking ends
            intOut <= intRequest && ackCount == 2'h0
                      && !(wrDev && wrData[scr_pkg::BIT_INT_ACK]);
        end
    end

    // power-down leaves only through a reset
    always_ff @(posedge clk) begin
        if (reset || softActive) begin
            powerDown <= 1'b0;
        end else if (wrDev && wrData[scr_pkg::BIT_POWER_DOWN]) begin
            powerDown <= 1'b1;
        end
    end

    // transmit enable; disable is deferred while a character is on the wire
    always_ff @(posedge clk) begin
        if (reset || softActive) begin
            txEnable      <= 1'b0;
            txStopPending <= 1'b0;
        end else if (wrTx && (wrData[scr_pkg::BIT_TX_EN] || wrData[scr_pkg::BIT_FLUSH_TXM])) begin
            txEnable      <= 1'b1;
            txStopPending <= 1'b0;
        end else if (wrTx && wrData[scr_pkg::BIT_TX_DIS]) begin
            txEnable      <= txBusy;
            txStopPending <= txBusy;
        end else if (txStopPending && !txBusy) begin
            txEnable      <= 1'b0;
            txStopPending <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || softActive) begin
            rxEnable <= 1'b0;
        end else if (wrRx && (wrData[scr_pkg::BIT_RX_EN] || wrData[scr_pkg::BIT_FLUSH_RXM])) begin
            rxEnable <= 1'b1;
        end else if (wrRx && wrData[scr_pkg::BIT_RX_DIS]) begin
            rxEnable <= 1'b0;
        end
    end

    // lock only gates fifo writes; receive status keeps flowing
    always_ff @(posedge clk) begin
        if (reset || softActive) begin
            rxFifoLocked <= 1'b0;
        end else if (wrRx && (wrData[scr_pkg::BIT_OPEN_RXF] || wrData[scr_pkg::BIT_FLUSH_RXM])) begin
            rxFifoLocked <= 1'b0;
        end else if (wrRx && wrData[scr_pkg::BIT_LOCK_RXF]) begin
            rxFifoLocked <= 1'b1;
        end
    end

    // gate bits hold their value after the write
    always_ff @(posedge clk) begin
        if (reset || softActive) begin
            timerAGate <= 1'b0;
            timerBGate <= 1'b0;
        end else if (wrTm) begin
            if (!timerABaud) begin
                timerAGate <= wrData[scr_pkg::BIT_GATE_A];
            end
            if (!timerBBaud) begin
                timerBGate <= wrData[scr_pkg::BIT_GATE_B];
            end
        end
    end

    // expired flags: terminal count wins over status clear
    always_ff @(posedge clk) begin
        if (reset || softActive) begin
            timerAExpired <= 1'b0;
            timerBExpired <= 1'b0;
        end else begin
            timerAExpired <= timerATerminal || (timerAExpired && !statusClear);
            timerBExpired <= timerBTerminal || (timerBExpired && !statusClear);
        end
    end

    always_ff @(posedge clk) begin
        if (reset || softActive) begin
            modemControl <= scr_pkg::MODEM_RESET;
            txFlags      <= scr_pkg::FLAGS_RESET;
        end else if (wrStrobe && addr == scr_pkg::ADDR_MODEM_CONTROL) begin
            modemControl <= wrData;
        end else if (wrStrobe && addr == scr_pkg::ADDR_TX_FLAGS) begin
            txFlags <= {5'h00, wrData[2:0] & scr_pkg::TX_FLAG_MASK};
        end
    end

    // pins not set as general outputs idle high (inactive)
    always_ff @(posedge clk) begin
        if (reset || softActive) begin
            dtrPin         <= 1'b1;
            rtsPin         <= 1'b1;
            gpOutputOne    <= 1'b1;
            gpOutputTwo    <= 1'b1;
            gpOutputZero   <= 1'b1;
            loopbackActive <= 1'b0;
        end else begin
            dtrPin <= !(pinIsGpOut[0] && modemControl[scr_pkg::BIT_DTR]);
            rtsPin <= !(pinIsGpOut[1] && modemControl[scr_pkg::BIT_RTS]);
            gpOutputOne  <= !(pinIsGpOut[2] && modemControl[scr_pkg::BIT_GP_OUTPUT_ONE]);
            gpOutputTwo  <= !(pinIsGpOut[3] && modemControl[scr_pkg::BIT_GP_OUTPUT_TWO]);
            gpOutputZero <= !(pinIsGpOut[5] && modemControl[scr_pkg::BIT_GP_OUTPUT_ZERO]);
            // type of loopback comes from the mode register outside
            loopbackActive <= modemControl[scr_pkg::BIT_LOOP];
        end
    end

    // a write to a full fifo is dropped here: txPush stays low while txFifoFull is set
    always_ff @(posedge clk) begin
        if (reset || softActive) begin
            txPush     <= 1'b0;
            txPushData <= '0;
        end else begin
            txPush <= wrStrobe && addr == scr_pkg::ADDR_TX_DATA && !txFifoFull;
            if (wrStrobe && addr == scr_pkg::ADDR_TX_DATA) begin
                txPushData <= {txFlags[2:0], wrData};
            end
        end
    end

    // receive head holding register refilled from the fifo
    always_ff @(posedge clk) begin
        if (reset || softActive) begin
            rxDataHead  <= 8'h00;
            rxFlags     <= 8'h00;
            rxHeadValid <= 1'b0;
            rxFifoPop   <= 1'b0;
        end else begin
            rxFifoPop <= 1'b0;
            if ((!rxHeadValid || rdRxData) && rxFifoValid && !rxFifoPop) begin
                rxDataHead  <= rxFifoData;
                rxFlags     <= rxFifoFlags;
                rxHeadValid <= 1'b1;
                rxFifoPop   <= 1'b1;
            end else if (rdRxData) begin
                rxHeadValid <= 1'b0;
            end
        end
    end

    // read port; command and transmit data registers are write-only and read zero
    always_ff @(posedge clk) begin
        if (reset) begin
            rdData <= 8'h00;
        end else if (!rdStrobe) begin
            rdData <= 8'h00;
        end else if (addr == scr_pkg::ADDR_MODEM_CONTROL) begin
            rdData <= modemControl;
        end else if (addr == scr_pkg::ADDR_TX_FLAGS) begin
            rdData <= txFlags;
        end else if (addr == scr_pkg::ADDR_RX_DATA) begin
            rdData <= rxDataHead;
        end else if (addr == scr_pkg::ADDR_RX_FLAGS) begin
            rdData <= rxFlags;
        end else if (addr == scr_pkg::ADDR_STATE) begin
            rdData <= {rxHeadValid, powerDown, rxFifoLocked, rxEnable, txEnable,
                       timerBGate, timerAGate, timerAExpired | timerBExpired};
        end else begin
            rdData <= 8'h00;
        end
    end
endmodule

// ---- tb/scr_regs_chk.sv ----
// concurrent checks on the serial register front end ports
`timescale 1ns/1ps
module scr_regs_chk #(
    parameter int RX_WIDTH = 8
) (
    input wire logic                clk,
    input wire logic                reset,
    input wire logic [3:0]          addr,
    input wire logic [7:0]          wrData,
    input wire logic                wrStrobe,
    input wire logic                rdStrobe,
    input wire logic [7:0]          rdData,
    input wire logic                intOut,
    input wire logic                intRequest,
    input wire logic                deviceReset,
    input wire logic                statusClear,
    input wire logic                timerABaud,
    input wire logic                timerAGate,
    input wire logic                timerAStart,
    input wire logic                txFifoFull,
    input wire logic                txPush,
    input wire logic [RX_WIDTH+2:0] txPushData,
    input wire logic                rxFifoValid,
    input wire logic                rxFifoPop
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence devWr(logic [7:0] v);
        wrStrobe && addr == scr_pkg::ADDR_DEVICE_COMMAND && wrData == v;
    endsequence
    // a pending request shows again once the two blanked clocks are over
    sequence ackReturn;
        intOut || !$past(intRequest) || $past(wrStrobe) || $past(wrStrobe, 2);
    endsequence
    sequence timerWr;
        wrStrobe && addr == scr_pkg::ADDR_TIMER_COMMAND;
    endsequence
    cmd_pulse_a: assert property (devWr(8'h04) |=> statusClear ##1 !statusClear)
        else $error("status clear pulse not one cycle");
    soft_reset_a: assert property (devWr(8'h01) |=> deviceReset [*4] ##1 !deviceReset)
        else $error("soft reset length wrong");
    ack_low_a: assert property (devWr(8'h02) |=> !intOut [*2] ##1 ackReturn)
        else $error("interrupt not held off after ack");
    gate_keep_a: assert property (timerWr ##0 !timerABaud |=> timerAGate == $past(wrData[2]))
        else $error("timer gate does not follow write");
    baud_ignore_a: assert property (timerWr ##0 timerABaud |=> $stable(timerAGate) && !timerAStart)
        else $error("timer command acted on baud timer");
    tx_push_a: assert property (wrStrobe && addr == scr_pkg::ADDR_TX_DATA |=>
        txPush != $past(txFifoFull) && (!txPush || txPushData[7:0] == $past(wrData)))
        else $error("transmit push wrong");
    rx_pop_a: assert property (rdStrobe && addr == scr_pkg::ADDR_RX_DATA && rxFifoValid && !rxFifoPop
        |=> rxFifoPop)
        else $error("receive read did not take next entry");
    rd_idle_a: assert property (!rdStrobe |=> rdData == 8'h00)
        else $error("read data outside read cycle");
endmodule
bind scr_regs scr_regs_chk #(.RX_WIDTH(RX_WIDTH)) chk_i (
    .clk(clk), .reset(reset), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .intOut(intOut), .intRequest(intRequest),
    .deviceReset(deviceReset),
    .statusClear(statusClear), .timerABaud(timerABaud), .timerAGate(timerAGate),
    .timerAStart(timerAStart), .txFifoFull(txFifoFull), .txPush(txPush),
    .txPushData(txPushData), .rxFifoValid(rxFifoValid), .rxFifoPop(rxFifoPop)
);

// ---- tb/scr_rx_fifo_model.sv ----
// receive fifo model that feeds the register front end its head entry
`timescale 1ns/1ps
module scr_rx_fifo_model (
    input  wire logic       clk,
    input  wire logic       clear,
    input  wire logic       flushRxFifo,
    input  wire logic       rxFifoPop,
    output logic            rxFifoValid,
    output logic [7:0]      rxFifoData,
    output logic [7:0]      rxFifoFlags
);
    logic [15:0] entries[$];
    logic [15:0] idle = 16'h5aa5;
    initial rxFifoValid = 1'b0;
    task automatic push(input logic [15:0] e);
        entries.push_back(e);
    endtask
    // an empty fifo shows a toggling pattern so stale data never looks valid
    always @(posedge clk) begin
        if (clear || flushRxFifo) begin
            entries.delete();
        end else if (rxFifoPop && entries.size() > 0) begin
            void'(entries.pop_front());
        end
        idle <= ~idle;
        rxFifoValid <= entries.size() > 0;
        {rxFifoFlags, rxFifoData} <= (entries.size() > 0) ? entries[0] : idle;
    end
endmodule

// ---- tb/scr_regs_test.sv ----
// self-checking bench for the serial register front end
`timescale 1ns/1ps
module scr_regs_test;
    logic clk, reset, wrStrobe, rdStrobe, intRequest, txBusy, timerABaud, timerATerminal;
    logic txFifoFull, intOut, deviceReset, statusClear, powerDown, flushTxMachine;
    logic flushTxFifo, txEnable, flushRxMachine, flushRxFifo, rxEnable, rxFifoLocked;
    logic timerAGate, timerBGate, timerAStart, timerBStart, timerAExpired, dtrPin, rtsPin;
    logic gpOutputOne, gpOutputTwo, gpOutputZero, loopbackActive, txPush, rxFifoValid;
    logic rxFifoPop, timerBBaud, timerBTerminal, timerBExpired;
    logic [3:0]  addr;
    logic [7:0]  wrData, rdData, rxFifoData, rxFifoFlags, rd;
    logic [5:0]  pinIsGpOut;
    logic [10:0] txPushData;
    int          miscompares = 0;
    int          total_checks = 0;
    int          n;
    scr_regs #(.RX_WIDTH(8)) dut (
        .clk(clk), .reset(reset), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdData(rdData), .intRequest(intRequest), .intOut(intOut),
        .deviceReset(deviceReset), .statusClear(statusClear), .powerDown(powerDown),
        .flushTxMachine(flushTxMachine), .flushTxFifo(flushTxFifo), .txEnable(txEnable),
        .txBusy(txBusy), .flushRxMachine(flushRxMachine), .flushRxFifo(flushRxFifo),
        .rxEnable(rxEnable), .rxFifoLocked(rxFifoLocked), .timerABaud(timerABaud),
        .timerBBaud(timerBBaud), .timerAGate(timerAGate), .timerBGate(timerBGate),
        .timerAStart(timerAStart), .timerBStart(timerBStart),
        .timerATerminal(timerATerminal), .timerBTerminal(timerBTerminal),
        .timerAExpired(timerAExpired), .timerBExpired(timerBExpired), .pinIsGpOut(pinIsGpOut),
        .dtrPin(dtrPin), .rtsPin(rtsPin), .gpOutputOne(gpOutputOne),
        .gpOutputTwo(gpOutputTwo), .gpOutputZero(gpOutputZero),
        .loopbackActive(loopbackActive), .txPushData(txPushData), .txPush(txPush),
        .txFifoFull(txFifoFull), .rxFifoValid(rxFifoValid), .rxFifoData(rxFifoData),
        .rxFifoFlags(rxFifoFlags), .rxFifoPop(rxFifoPop)
    );
    scr_rx_fifo_model fifo (
        .clk(clk), .clear(deviceReset), .flushRxFifo(flushRxFifo), .rxFifoPop(rxFifoPop),
        .rxFifoValid(rxFifoValid), .rxFifoData(rxFifoData), .rxFifoFlags(rxFifoFlags)
    );
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // one command per write, strobe held a single cycle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
        #1;
    endtask
    task automatic rdReg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1 rd = rdData;
    endtask
    task automatic hwReset;
        @(posedge clk);
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk({deviceReset, dtrPin, rtsPin, txPush}, 4'he);
        @(posedge clk);
        reset <= 1'b0;
        #1;
    endtask
    task automatic testModem;
        wr(4'h4, 8'h3f);
        tick(1);
        chk({dtrPin, rtsPin, gpOutputOne, gpOutputTwo, gpOutputZero}, 5'h0);
        chk(loopbackActive, 1'b1);
        @(posedge clk);
        pinIsGpOut <= 6'h3e;
        tick(2);
        chk({dtrPin, rtsPin}, 2'h2);
        rdReg(4'h4);
        chk(rd, 8'h3f);
        rdReg(4'h0);
        chk(rd, 8'h00);
        rdReg(4'hf);
        chk(rd, 8'h00);
        $display("modem test done");
    endtask
    task automatic testCmds;
        wr(4'h1, 8'h04);
        chk(txEnable, 1'b1);
        @(posedge clk);
        txBusy <= 1'b1;
        wr(4'h1, 8'h08);
        tick(2);
        chk(txEnable, 1'b1);
        @(posedge clk);
        txBusy <= 1'b0;
        for (n = 0; n < 8 && txEnable !== 1'b0; n++) begin
            tick(1);
        end
        chk(txEnable, 1'b0);
        if (n == 8) give_verdict();
        wr(4'h1, 8'h01);
        chk(flushTxMachine, 1'b1);
        tick(1);
        chk({flushTxMachine, txEnable}, 2'h1);
        wr(4'h1, 8'h02);
        chk(flushTxFifo, 1'b1);
        wr(4'h2, 8'h01);
        chk(rxEnable, 1'b1);
        wr(4'h2, 8'h10);
        chk({rxEnable, rxFifoLocked}, 2'h3);
        wr(4'h2, 8'h20);
        chk(rxFifoLocked, 1'b0);
        wr(4'h2, 8'h10);
        wr(4'h2, 8'h02);
        chk({rxEnable, rxFifoLocked}, 2'h1);
        wr(4'h2, 8'h04);
        chk(flushRxMachine, 1'b1);
        tick(1);
        chk({rxEnable, rxFifoLocked}, 2'h2);
        wr(4'h2, 8'h08);
        chk(flushRxFifo, 1'b1);
        tick(1);
        chk(flushRxFifo, 1'b0);
        $display("command test done");
    endtask
    task automatic testTimer;
        wr(4'h3, 8'h0d);
        chk({timerAStart, timerAGate, timerBGate}, 3'h7);
        @(posedge clk);
        timerABaud <= 1'b1;
        wr(4'h3, 8'h02);
        chk({timerAStart, timerAGate, timerBStart, timerBGate}, 4'h6);
        @(posedge clk);
        timerABaud <= 1'b0;
        timerBBaud <= 1'b1;
        wr(4'h3, 8'h0f);
        chk({timerAStart, timerAGate, timerBStart, timerBGate}, 4'hc);
        @(posedge clk);
        timerBBaud <= 1'b0;
        timerATerminal <= 1'b1;
        timerBTerminal <= 1'b1;
        @(posedge clk);
        timerATerminal <= 1'b0;
        timerBTerminal <= 1'b0;
        tick(1);
        chk({timerAExpired, timerBExpired, timerAGate}, 3'h7);
        wr(4'h0, 8'h04);
        tick(1);
        chk({timerAExpired, timerBExpired}, 2'h0);
        $display("timer test done");
    endtask
    task automatic testTx;
        for (n = 0; n < 3; n++) begin
            wr(4'h6, 8'(1 << n));
            wr(4'h5, 8'h3c);
            chk({txPush, txPushData}, {1'b1, 3'(1 << n), 8'h3c});
        end
        rdReg(4'h6);
        chk(rd, 8'h04);
        @(posedge clk);
        txFifoFull <= 1'b1;
        wr(4'h5, 8'h11);
        chk(txPush, 1'b0);
        $display("transmit test done");
    endtask
    task automatic testRx;
        fifo.push(16'h81c3);
        fifo.push(16'h0242);
        tick(4);
        rdReg(4'h8);
        chk(rd, 8'h81);
        rdReg(4'h7);
        chk(rd, 8'hc3);
        rdReg(4'h8);
        chk(rd, 8'h02);
        rdReg(4'h7);
        chk(rd, 8'h42);
        $display("receive test done");
    endtask
    task automatic testDev;
        wr(4'h0, 8'h01);
        for (n = 0; n < 8 && deviceReset === 1'b1; n++) begin
            tick(1);
        end
        chk(16'(n), 16'h4);
        if (n == 8) give_verdict();
        chk(loopbackActive, 1'b0);
        @(posedge clk);
        intRequest <= 1'b1;
        tick(1);
        chk(intOut, 1'b1);
        wr(4'h0, 8'h02);
        chk(intOut, 1'b0);
        tick(1);
        chk(intOut, 1'b0);
        tick(1);
        chk(intOut, 1'b1);
        wr(4'h0, 8'h08);
        chk(powerDown, 1'b1);
        rdReg(4'h9);
        chk(rd, 8'h40);
        hwReset();
        chk(powerDown, 1'b0);
        $display("device test done");
    endtask
    initial begin
        {reset, wrStrobe, rdStrobe, intRequest, txBusy, timerABaud, timerATerminal} = '0;
        {addr, wrData, txFifoFull, timerBBaud, timerBTerminal} = '0;
        pinIsGpOut = 6'h3f;
        hwReset();
        testModem();
        testCmds();
        testTimer();
        testTx();
        testRx();
        testDev();
        give_verdict();
    end
endmodule
